// ===== design/ufil_defs.svh
// Purpose: Offsets, bit positions, reset values and timing counts for ufil.
// Assumes: Word-aligned registers on a 32-bit classic Wishbone bus.
// Notes: Byte address is four times the register index.
`ifndef UFIL_DEFS_SVH
`define UFIL_DEFS_SVH

// Register indexes
`define UFIL_IDX_IER 4'h1
`define UFIL_IDX_ISR 4'h2
`define UFIL_IDX_MCR 4'h4
`define UFIL_IDX_MSR 4'h6
`define UFIL_IDX_FCTR 4'h8
`define UFIL_IDX_EFR 4'h9
`define UFIL_IDX_THR 5'h10
`define UFIL_ADDR_W 8

// Enhanced function bits
`define UFIL_EFR_AUTO_IN 7
`define UFIL_EFR_AUTO_OUT 6
`define UFIL_EFR_ENH 4
// Interrupt enable bits
`define UFIL_IER_IN_DEASSERT 7
`define UFIL_IER_OUT_DEASSERT 6
// Interrupt status bit
`define UFIL_ISR_FLOW 5
// Modem control bits
`define UFIL_MCR_IR 6
`define UFIL_MCR_LOOP 4
`define UFIL_MCR_SEL 2
`define UFIL_MCR_RTS 1
`define UFIL_MCR_DTR 0
// Feature control bit: invert receive input ahead of the decoder
`define UFIL_FCTR_RX_INV 2
// Threshold register fields
`define UFIL_THR_HI_LSB 0
`define UFIL_THR_LO_LSB 8
`define UFIL_THR_OP1 16
`define UFIL_THR_OP2 17

// Reset values
`define UFIL_THR_RESET 32'h0000_1038
`define UFIL_REG_RESET 8'h00

// Infrared timing in 16X ticks
`define UFIL_IR_PULSE_TICKS 3
`define UFIL_IR_BIT_TICKS 16

`endif

// ===== design/ufil_pkg.sv
// Purpose: Types shared by the ufil block.
// Assumes: Nothing beyond the defines header.
// Notes: Only the transmit gate has a state machine.
package ufil_pkg;

    // Transmit gate state
    typedef enum logic [0:0] {
        UFIL_TX_RUN,
        UFIL_TX_HELD
    } ufil_tx_state_t;

endpackage

// ===== design/ufil_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps

module ufil_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ufil_sync_t;

    ufil_sync_t st_q;
    ufil_sync_t st_d;

    // Shift the pin through both stages
    always_comb
    begin
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    // Idle-high pins are forced high in reset; zero-valued bits keep tracking
    // the pin, so a strap sampled at reset release has already settled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q.s1 <= d_i | RST_VAL;
            st_q.s2 <= st_q.s1 | RST_VAL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule

// ===== design/ufil_top.sv
// Purpose: UART channel flow control, infrared codec and internal loopback.
// Assumes: Core transmitter, receiver and FIFO sit outside; bit_tick_i is the
//          16X enable on clk_i; tx_bit_start_i marks each transmit bit cell.
// Notes: Registers reached over classic Wishbone, one word per index.
//
// Contract
// - Select 0: enhanced bit 7 auto CTS, bit 6 auto RTS.
// - Select 1: same bits give auto DSR/DTR; both clear means none.
// - Auto RTS acts only once modem control bit 1 asserts RTS.
// - Auto DTR acts only once modem control bit 0 asserts DTR.
// - Flow interrupt enables writable and effective only with enhanced bit 4.
// - Interrupt enable bit 7 flags monitored input de-assertion, CTS or DSR.
// - Interrupt enable bit 6 flags controlled output de-assertion, RTS or DTR.
// - Monitored input rising with enable sets status bit 5.
// - High flow input lets current character finish, then no new start.
// - Held transmitter resumes once flow input returns low.
// - Receive fill reaching upper threshold de-asserts the auto output.
// - Fill falling to lower threshold re-asserts the auto output.
// - Infrared startup pin sampled at reset release into control bit 6.
// - Software writes to control bit 6 override the sampled value.
// - Infrared receiver blanked while the transmitter is sending.
// - Infrared transmit idles low; low receive input is idle.
// - Each zero bit emits one 3/16-bit pulse; a one emits none.
// - Each detected light pulse yields a zero in the received stream.
// - Register option inverts receive input ahead of the decoder.
// - Control bit 4 loops transmit shifter into receive shifter.
// - Loopback drives transmit, RTS, DTR high and ignores modem inputs.
`timescale 1ns/1ps
`include "ufil_defs.svh"

module ufil_top
    import ufil_pkg::*;
#(
    parameter int FILL_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`UFIL_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core side
    input wire logic bit_tick_i,
    input wire logic tx_bit_start_i,
    input wire logic tx_serial_i,
    input wire logic tx_busy_i,
    input wire logic [FILL_W-1:0] rx_fill_level_i,
    output logic tx_allow_o,
    output logic rx_serial_o,
    // Line pins
    output logic tx_o,
    input wire logic rx_i,
    output logic rts_n_o,
    output logic dtr_n_o,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic carrier_detect_n_i,
    input wire logic ring_indicator_n_i,
    input wire logic ir_startup_enable_pin_i
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_function_reg;
        logic [7:0] fctr;
        logic [17:0] thr;
        logic isr_flow;
        logic rst_seen;
        ufil_tx_state_t tx_st;
        logic out_hold;
        logic mon_prev;
        logic ctl_prev;
        logic [3:0] enc_cnt;
        logic enc_zero;
        logic [3:0] dec_cnt;
        logic dec_busy;
        logic rx_prev;
        logic tx_pin;
        logic rx_out;
        logic rts_pin;
        logic dtr_pin;
    } ufil_state_t;

    ufil_state_t st_q;
    ufil_state_t st_d;

    // Pin inputs cross into clk_i; idle levels are high except infrared enable
    logic [5:0] pins_s;
    ufil_sync #(
        .W(6),
        .RST_VAL(6'h3E)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({rx_i, cts_n_i, dsr_n_i, carrier_detect_n_i, ring_indicator_n_i,
              ir_startup_enable_pin_i}),
        .q_o(pins_s)
    );

    logic rx_s;
    logic cts_s;
    logic dsr_s;
    logic cd_s;
    logic ri_s;
    logic ir_pin_s;
    assign {rx_s, cts_s, dsr_s, cd_s, ri_s, ir_pin_s} = pins_s;

    // Decoded controls
    logic sel;
    logic loop;
    logic ir_mode;
    logic enh;
    logic auto_in;
    logic auto_out;
    logic rts_on;
    logic dtr_on;
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
    logic mon_n;
    logic ctl_n;
    logic [FILL_W-1:0] hi_lvl;
    logic [FILL_W-1:0] lo_lvl;
    logic acc;
    logic [3:0] idx;
    logic idx_ok;
    logic [7:0] msr;
    logic rx_dec_in;

    assign sel = st_q.modem_control_reg[`UFIL_MCR_SEL];
    assign loop = st_q.modem_control_reg[`UFIL_MCR_LOOP];
    assign ir_mode = st_q.modem_control_reg[`UFIL_MCR_IR];
    assign enh = st_q.enhanced_function_reg[`UFIL_EFR_ENH];
    assign auto_in = st_q.enhanced_function_reg[`UFIL_EFR_AUTO_IN];
    assign auto_out = st_q.enhanced_function_reg[`UFIL_EFR_AUTO_OUT];
    assign hi_lvl = st_q.thr[`UFIL_THR_HI_LSB +: FILL_W];
    assign lo_lvl = st_q.thr[`UFIL_THR_LO_LSB +: FILL_W];

    assign rts_on = st_q.modem_control_reg[`UFIL_MCR_RTS] & ~(auto_out & ~sel & st_q.out_hold);
    assign dtr_on = st_q.modem_control_reg[`UFIL_MCR_DTR] & ~(auto_out & sel & st_q.out_hold);

    assign cts_n = loop ? ~rts_on : cts_s;
    assign dsr_n = loop ? ~dtr_on : dsr_s;
    assign ri_n = loop ? ~st_q.thr[`UFIL_THR_OP1] : ri_s;
    assign cd_n = loop ? ~st_q.thr[`UFIL_THR_OP2] : cd_s;

    // Monitored input and controlled output of the selected pair
    assign mon_n = sel ? dsr_n : cts_n;
    assign ctl_n = sel ? ~dtr_on : ~rts_on;
    assign msr = {~cd_n, ~ri_n, ~dsr_n, ~cts_n, 4'h0};

    assign rx_dec_in = st_q.fctr[`UFIL_FCTR_RX_INV] ? ~rx_s : rx_s;

    // Bus decode; one word per index, so low two address bits are ignored
    assign acc = wb_cyc_i & wb_stb_i & ~st_q.ack;
    assign idx = wb_adr_i[5:2];
    assign idx_ok = (wb_adr_i[7:6] == 2'h0);

    // Next-state logic for the whole channel
    always_comb
    begin
        st_d = st_q;
        st_d.ack = acc;
        st_d.rst_seen = 1'b1;

        // Catch startup pin once after reset
        if (!st_q.rst_seen)
        begin
            st_d.modem_control_reg[`UFIL_MCR_IR] = ir_pin_s;
        end

        // Register reads; unmapped words read zero
        if (acc && !wb_we_i)
        begin
            st_d.rdata = 32'h0000_0000;
            if (wb_adr_i[7:2] == 6'(`UFIL_IDX_THR))
            begin
                st_d.rdata = {14'h0000, st_q.thr};
            end
            else if (idx_ok)
            begin
                case (idx)
                    `UFIL_IDX_IER: st_d.rdata = {24'h000000, st_q.interrupt_enable_reg};
                    `UFIL_IDX_ISR:
                        st_d.rdata = {26'h0000000, st_q.isr_flow, 4'h0, ~st_q.isr_flow};
                    `UFIL_IDX_MCR: st_d.rdata = {24'h000000, st_q.modem_control_reg};
                    `UFIL_IDX_MSR: st_d.rdata = {24'h000000, msr};
                    `UFIL_IDX_FCTR: st_d.rdata = {24'h000000, st_q.fctr};
                    `UFIL_IDX_EFR: st_d.rdata = {24'h000000, st_q.enhanced_function_reg};
                    default: st_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Register writes on lane 0 (lanes 1 and 2 also for the threshold register)
        if (acc && wb_we_i)
        begin
            if (wb_adr_i[7:2] == 6'(`UFIL_IDX_THR))
            begin
                if (wb_sel_i[0])
                begin
                    st_d.thr[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1])
                begin
                    st_d.thr[15:8] = wb_dat_i[15:8];
                end
                if (wb_sel_i[2])
                begin
                    st_d.thr[17:16] = wb_dat_i[17:16];
                end
            end
            else if (idx_ok && wb_sel_i[0])
            begin
                case (idx)
                    `UFIL_IDX_IER:
                    begin
                        st_d.interrupt_enable_reg[5:0] = wb_dat_i[5:0];
                        if (enh)
                        begin
                            st_d.interrupt_enable_reg[7:6] = wb_dat_i[7:6];
                        end
                    end
                    `UFIL_IDX_MCR: st_d.modem_control_reg = wb_dat_i[7:0];
                    `UFIL_IDX_FCTR: st_d.fctr = wb_dat_i[7:0];
                    `UFIL_IDX_EFR: st_d.enhanced_function_reg = wb_dat_i[7:0];
                    default: st_d.interrupt_enable_reg = st_q.interrupt_enable_reg;
                endcase
            end
        end

        // Reading the status clears the flow flag
        if (acc && !wb_we_i && idx_ok && idx == `UFIL_IDX_ISR)
        begin
            st_d.isr_flow = 1'b0;
        end

        st_d.mon_prev = mon_n;
        st_d.ctl_prev = ctl_n;
        if (enh && st_q.interrupt_enable_reg[`UFIL_IER_IN_DEASSERT] && mon_n && !st_q.mon_prev)
        begin
            st_d.isr_flow = 1'b1;
        end
        if (enh && st_q.interrupt_enable_reg[`UFIL_IER_OUT_DEASSERT] && ctl_n && !st_q.ctl_prev)
        begin
            st_d.isr_flow = 1'b1;
        end

        if (rx_fill_level_i >= hi_lvl)
        begin
            st_d.out_hold = 1'b1;
        end
        else if (rx_fill_level_i <= lo_lvl)
        begin
            st_d.out_hold = 1'b0;
        end

        // Transmit gate; the core owns character framing
        case (st_q.tx_st)
            UFIL_TX_RUN:
            begin
                if (auto_in && mon_n && !tx_busy_i)
                begin
                    st_d.tx_st = UFIL_TX_HELD;
                end
            end
            UFIL_TX_HELD:
            begin
                if (!auto_in || !mon_n)
                begin
                    st_d.tx_st = UFIL_TX_RUN;
                end
            end
            default: st_d.tx_st = UFIL_TX_RUN;
        endcase

        // Encoder pulses only on zero bits
        if (tx_bit_start_i)
        begin
            st_d.enc_cnt = 4'h0;
            st_d.enc_zero = ~tx_serial_i;
        end
        else if (bit_tick_i && st_q.enc_cnt != 4'hF)
        begin
            st_d.enc_cnt = st_q.enc_cnt + 4'h1;
        end

        // Light pulse gives a zero bit
        st_d.rx_prev = rx_dec_in;
        if (tx_busy_i)
        begin
            st_d.dec_busy = 1'b0;
        end
        else if (rx_dec_in && !st_q.rx_prev)
        begin
            st_d.dec_busy = 1'b1;
            st_d.dec_cnt = 4'h0;
        end
        else if (bit_tick_i && st_q.dec_busy)
        begin
            st_d.dec_cnt = st_q.dec_cnt + 4'h1;
            if (st_q.dec_cnt == 4'(`UFIL_IR_BIT_TICKS - 1))
            begin
                st_d.dec_busy = 1'b0;
            end
        end

        // Registered line outputs
        if (loop)
        begin
            st_d.tx_pin = 1'b1;
            st_d.rts_pin = 1'b1;
            st_d.dtr_pin = 1'b1;
            st_d.rx_out = tx_serial_i;
        end
        else
        begin
            st_d.rts_pin = ~rts_on;
            st_d.dtr_pin = ~dtr_on;
            if (ir_mode)
            begin
                st_d.tx_pin = st_q.enc_zero && tx_busy_i && !tx_bit_start_i &&
                    (st_q.enc_cnt < 4'(`UFIL_IR_PULSE_TICKS));
                st_d.rx_out = ~st_q.dec_busy | tx_busy_i;
            end
            else
            begin
                st_d.tx_pin = tx_serial_i;
                st_d.rx_out = rx_s;
            end
        end
    end

    // Single state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
            st_q.interrupt_enable_reg <= `UFIL_REG_RESET;
            st_q.modem_control_reg <= `UFIL_REG_RESET;
            st_q.enhanced_function_reg <= `UFIL_REG_RESET;
            st_q.fctr <= `UFIL_REG_RESET;
            st_q.thr <= 18'(`UFIL_THR_RESET);
            st_q.tx_st <= UFIL_TX_RUN;
            st_q.mon_prev <= 1'b1;
            st_q.ctl_prev <= 1'b1;
            st_q.rx_prev <= 1'b1; // Matches synced reset level, no false pulse
            st_q.tx_pin <= 1'b1;
            st_q.rx_out <= 1'b1;
            st_q.rts_pin <= 1'b1;
            st_q.dtr_pin <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdata;
    assign tx_allow_o = (st_q.tx_st == UFIL_TX_RUN);
    assign tx_o = st_q.tx_pin;
    assign rx_serial_o = st_q.rx_out;
    assign rts_n_o = st_q.rts_pin;
    assign dtr_n_o = st_q.dtr_pin;
endmodule

// ===== verif/ufil_top_assertions.sv
// Purpose: Port-level checks for ufil_top.
// Assumes: One clock; mode bits mirrored from bus writes.
// Notes: Mode checks wait until the mirror has caught up.
`timescale 1ns/1ps
`include "ufil_defs.svh"

module ufil_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`UFIL_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic bit_tick_i,
    input wire logic tx_serial_i,
    input wire logic tx_busy_i,
    input wire logic tx_allow_o,
    input wire logic rx_serial_o,
    input wire logic tx_o,
    input wire logic rts_n_o,
    input wire logic dtr_n_o,
    input wire logic ir_startup_enable_pin_i
);
    logic loop_q, ir_q, mw, ok, irm;
    logic [1:0] up_q;
    logic [3:0] tk_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Modem control write seen at its ack
    assign mw = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h10;
    assign ok = up_q == 2'h3;
    assign irm = ok && ir_q && !loop_q;
    // Mirror lags the design by a cycle, so checks stay safe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            loop_q <= 1'h0;
            ir_q <= ir_startup_enable_pin_i;
            up_q <= 2'h0;
            tk_q <= 4'h0;
        end
        else
        begin
            loop_q <= mw ? wb_dat_i[`UFIL_MCR_LOOP] : loop_q;
            ir_q <= mw ? wb_dat_i[`UFIL_MCR_IR] : ir_q;
            up_q <= up_q + {1'h0, !ok};
            tk_q <= tx_o ? tk_q + {3'h0, bit_tick_i} : 4'h0;
        end
    end
    property p_ack_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack late");
    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_req;
        wb_ack_o |-> wb_cyc_i && $past(wb_stb_i);
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack unasked");
    property p_hold_idle;
        $fell(tx_allow_o) |-> !$past(tx_busy_i);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("hold mid char");
    property p_loop_pins;
        ok && loop_q && $past(loop_q) |-> tx_o && rts_n_o && dtr_n_o;
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("loop pins low");
    property p_loop_data;
        ok && loop_q && $past(loop_q) |-> rx_serial_o == $past(tx_serial_i);
    endproperty
    a_loop_data: assert property (p_loop_data) else $error("loop data");
    property p_ir_idle;
        irm && $past(ir_q) && !tx_busy_i && !$past(tx_busy_i) && !$past(tx_busy_i, 2)
            |-> !tx_o;
    endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("ir tx not idle");
    property p_ir_blank;
        irm && $past(ir_q) && $past(tx_busy_i) |-> rx_serial_o;
    endproperty
    a_ir_blank: assert property (p_ir_blank) else $error("ir rx open");
    property p_ir_width;
        irm && $past(ir_q) && tx_o |-> tk_q <= 4'h3;
    endproperty
    a_ir_width: assert property (p_ir_width) else $error("ir pulse long");
endmodule

bind ufil_top ufil_chk i_ufil_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .bit_tick_i(bit_tick_i), .tx_serial_i(tx_serial_i),
    .tx_busy_i(tx_busy_i), .tx_allow_o(tx_allow_o), .rx_serial_o(rx_serial_o), .tx_o(tx_o),
    .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .ir_startup_enable_pin_i(ir_startup_enable_pin_i));

// ===== verif/ufil_remote.sv
// Purpose: Remote station on the line side.
// Assumes: Bench asks it to pause us and to send light pulses.
// Notes: LAT sets how slowly its handshake lines follow.
`timescale 1ns/1ps

module ufil_remote #(
    parameter int LAT = 2
) (
    input wire logic clk_i,
    input wire logic [1:0] hold_i,
    input wire logic send_i,
    input wire logic inv_i,
    input wire logic rts_n_i,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic rx_o
);
    logic [7:0] c_q = '0;
    logic [7:0] d_q = '0;
    logic [3:0] pl_q = '0;
    logic pend_q = '0;
    // Handshake lines lag the request by LAT+1 cycles
    always_ff @(posedge clk_i)
    begin
        c_q <= {c_q[6:0], hold_i[0]};
        d_q <= {d_q[6:0], hold_i[1]};
    end
    assign cts_n_o = c_q[LAT];
    assign dsr_n_o = d_q[LAT];
    always_ff @(posedge clk_i)
    begin
        if (send_i)
            pend_q <= 1'h1;
        else if (pend_q && !rts_n_i)
        begin
            pend_q <= 1'h0;
            pl_q <= 4'h4;
        end
        else if (pl_q != 4'h0)
            pl_q <= pl_q - 4'h1;
    end
    // Some modules deliver active-low pulses
    assign rx_o = inv_i ^ (pl_q != 4'h0);
endmodule

// ===== verif/tb.sv
// Purpose: Self-checking bench for ufil_top.
// Assumes: 16X tick held high in infrared runs, one tick a cycle.
// Notes: Core and receive FIFO are stood in for by bench signals.
`timescale 1ns/1ps

module tb;
    logic clk_i = '0, rst_i = '1, cyc = '0, stb = '0, we = '0, ack, allow, rxs, tx, rts_n, dtr_n;
    logic tick = '0, bst = '0, tser = '1, tbusy = '0, ir_startup_enable_pin = '0, snd = '0, inv = '0;
    logic cts_n, dsr_n, rx;
    logic [1:0] hold = '0;
    logic [6:0] fill = '0;
    logic [7:0] adr = '0;
    logic [31:0] wd = '0, rdat, q;
    int num_errors = 0, n_checks = 0, wdog = 0, n;
    // Free-running clock
    always #2.5 clk_i = ~clk_i;
    ufil_top i_ufil_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_ack_o(ack), .bit_tick_i(tick), .tx_bit_start_i(bst), .tx_serial_i(tser),
        .tx_busy_i(tbusy), .rx_fill_level_i(fill), .tx_allow_o(allow), .rx_serial_o(rxs),
        .tx_o(tx), .rx_i(rx), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .cts_n_i(cts_n),
        .dsr_n_i(dsr_n), .carrier_detect_n_i(1'h1), .ring_indicator_n_i(1'h1),
        .ir_startup_enable_pin_i(ir_startup_enable_pin));
    ufil_remote #(.LAT(2)) i_ufil_remote (.clk_i(clk_i), .hold_i(hold), .send_i(snd),
        .inv_i(inv), .rts_n_i(rts_n), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .rx_o(rx));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task clks(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // Classic cycle; an idle edge follows so strobes never re-assert at once
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task rd(input string s, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(s, e, q);
    endtask
    task automatic wt(input string s, ref logic g, input logic v);
        int i;
        for (i = 0; i < 40 && g !== v; i++) @(posedge clk_i);
        chk(s, v, g);
    endtask
    // One-cycle strobe: 0 marks a bit start, 1 asks the remote for a pulse
    task kick(input logic which);
        if (which)
            snd <= 1'h1;
        else
            bst <= 1'h1;
        @(posedge clk_i);
        snd <= 1'h0;
        bst <= 1'h0;
    endtask
    task automatic cnt(ref logic s, input logic v);
        n = 0;
        repeat (20)
        begin
            @(posedge clk_i);
            n += (s === v);
        end
    endtask
    task t_regs;
        rd("isr_idle", 8'h08, 32'h01);
        rd("thresh", 8'h40, 32'h1038);
        wr(8'h04, 32'hC0);
        rd("ier_lock", 8'h04, 32'h00);
        wr(8'h24, 32'h10);
        wr(8'h04, 32'hC0);
        rd("ier", 8'h04, 32'hC0);
        rd("unmapped", 8'h3C, 32'h00);
    endtask
    task t_cts;
        wr(8'h24, 32'hD0);
        tbusy <= 1'h1;
        hold <= 2'h1;
        clks(8);
        chk("allow_busy", 1'h1, allow);
        tbusy <= 1'h0;
        wt("allow_cts", allow, 1'h0);
        rd("isr_cts", 8'h08, 32'h20);
        hold <= 2'h0;
        wt("allow_back", allow, 1'h1);
        wr(8'h10, 32'h04);
        hold <= 2'h1;
        clks(8);
        chk("allow_sel", 1'h1, allow);
        hold <= 2'h2;
        wt("allow_dsr", allow, 1'h0);
        rd("isr_dsr", 8'h08, 32'h20);
        wr(8'h24, 32'h10);
        wt("allow_none", allow, 1'h1);
        hold <= 2'h0;
    endtask
    task t_rts;
        wr(8'h24, 32'hD0);
        wr(8'h10, 32'h02);
        wt("rts_on", rts_n, 1'h0);
        fill <= 7'h38;
        wt("rts_hi", rts_n, 1'h1);
        rd("isr_rts", 8'h08, 32'h20);
        fill <= 7'h20;
        clks(8);
        chk("rts_mid", 1'h1, rts_n);
        fill <= 7'h10;
        wt("rts_lo", rts_n, 1'h0);
        wr(8'h10, 32'h05);
        wt("dtr_on", dtr_n, 1'h0);
        fill <= 7'h38;
        wt("dtr_hi", dtr_n, 1'h1);
        fill <= 7'h00;
        wr(8'h24, 32'h00);
    endtask
    task t_ir;
        tick <= 1'h1;
        wr(8'h10, 32'h42);
        clks(4);
        chk("ir_idle", 1'h0, tx);
        tbusy <= 1'h1;
        tser <= 1'h0;
        kick(1'h0);
        cnt(tx, 1'h1);
        chk("pulse_zero", 3, n);
        tser <= 1'h1;
        kick(1'h0);
        cnt(tx, 1'h1);
        chk("pulse_one", 0, n);
        kick(1'h1);
        cnt(rxs, 1'h0);
        chk("blank", 0, n);
        tbusy <= 1'h0;
        kick(1'h1);
        wt("dec", rxs, 1'h0);
        wt("dec_end", rxs, 1'h1);
        // Flipping pin and option gives one stray decode; let it run out
        inv <= 1'h1;
        wr(8'h20, 32'h04);
        clks(20);
        chk("inv_idle", 1'h1, rxs);
        kick(1'h1);
        // Leading-edge decode gives 15 low samples, a trailing-edge one 11
        cnt(rxs, 1'h0);
        chk("inv_dec", 15, n);
        wr(8'h20, 32'h00);
        inv <= 1'h0;
        wr(8'h10, 32'h00);
        clks(20);
    endtask
    task t_loop;
        wr(8'h40, 32'h31038);
        wr(8'h10, 32'h13);
        hold <= 2'h3;
        clks(4);
        chk("loop_pins", 3'h7, {tx, rts_n, dtr_n});
        bus(1'h0, 8'h18, 32'h0);
        chk("msr", 4'hF, q[7:4]);
        repeat (2)
        begin
            tser <= ~tser;
            clks(2);
            chk("loop_data", tser, rxs);
        end
        wr(8'h10, 32'h00);
        hold <= 2'h0;
    endtask
    task t_ir_startup_enable_pin;
        ir_startup_enable_pin <= 1'h1;
        rst_i <= 1'h1;
        clks(3);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd("ir_start", 8'h10, 32'h40);
        chk("ir_tx", 1'h0, tx);
        wr(8'h10, 32'h00);
        rd("ir_over", 8'h10, 32'h00);
    endtask
    // Main sequence after a three-cycle reset
    initial
    begin
        clks(3);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_regs;
        t_cts;
        t_rts;
        t_ir;
        t_loop;
        t_ir_startup_enable_pin;
        complete_run;
    end
    // Watchdog: the run needs a few thousand cycles at most
    always @(posedge clk_i)
    begin
        wdog++;
        if (wdog == 20000)
        begin
            num_errors++;
            complete_run;
        end
    end
endmodule
